//--- hdl/mpo_pkg.sv
// Purpose: Constants for the modem power-off sequencer
// Assumes: 125 MHz clock
// Notes: Long counts are parameters of the top module
package mpo_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   // Hold times in milliseconds
   localparam int unsigned OFF_HOLD_MS = 2000;
   localparam int unsigned ON_HOLD_MS = 5000;
   localparam int unsigned EMERG_HOLD_MS = 200;
   localparam longint unsigned OFF_HOLD_CYC =
      (longint'(OFF_HOLD_MS) * CLK_HZ + 999) / 1000;
   localparam longint unsigned ON_HOLD_CYC =
      (longint'(ON_HOLD_MS) * CLK_HZ + 999) / 1000;
   localparam longint unsigned EMERG_HOLD_CYC =
      (longint'(EMERG_HOLD_MS) * CLK_HZ + 999) / 1000;
   localparam int CNT_W = 30;
   localparam int DETACH_W = 16;
   localparam logic [DETACH_W-1:0] DETACH_TMO_CYC = 16'hffff;
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_ON = 5'h02,
      ST_DETACH = 5'h04,
      ST_WAIT_REL = 5'h08,
      ST_WAIT_ON_REL = 5'h10
   } mpo_state_t;
endpackage

//--- hdl/mpo_sequencer.sv
// Purpose: Power-on and power-off sequencing of a cellular modem
// Assumes: Inputs synchronous to clk; key and emergency lines active low
// Notes: Detach handshake goes to the protocol stack outside this block
// How it works
// - Shutdown command or long key press
// - Detach request precedes orderly power-down
// - Key shutdown starts after key release
// - Power-good low once off
// - Qualified emergency pulse always ends off
// - Emergency path sends no detach
// - Power-good high after power-on
`timescale 1ns/100ps
module mpo_sequencer #(
   parameter logic [mpo_pkg::CNT_W-1:0] OFF_HOLD =
      mpo_pkg::CNT_W'(mpo_pkg::OFF_HOLD_CYC),
   parameter logic [mpo_pkg::CNT_W-1:0] ON_HOLD =
      mpo_pkg::CNT_W'(mpo_pkg::ON_HOLD_CYC),
   parameter logic [mpo_pkg::CNT_W-1:0] EMERG_HOLD =
      mpo_pkg::CNT_W'(mpo_pkg::EMERG_HOLD_CYC)
) (
   input wire logic clk, // 125 MHz clock
   input wire logic rst_b, // Async reset, active low
   input wire logic power_key_n, // Power key, active low
   input wire logic emergency_off_n, // Emergency off, active low
   input wire logic shutdown_command, // Software shutdown pulse
   input wire logic detach_done, // Network detach finished pulse
   output logic power_good_out, // High while powered on
   output logic detach_req // Detach request level
);
   // ******************************
   // Hold counters and detach timeout counter
   // ******************************
   mpo_pkg::mpo_state_t state_ff, nxt_state;
   logic [mpo_pkg::CNT_W-1:0] key_cnt_ff, emg_cnt_ff;
   logic [mpo_pkg::DETACH_W-1:0] det_cnt_ff;
   logic emg_armed_ff;
   wire key_low = ~power_key_n;
   wire off_held = key_cnt_ff >= OFF_HOLD;
   wire on_held = key_cnt_ff >= ON_HOLD;
   wire emg_fire = emg_armed_ff & emergency_off_n;
   wire det_end = detach_done | (det_cnt_ff == mpo_pkg::DETACH_TMO_CYC);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_cnt_ff <= '0;
      end else if (!key_low) begin
         key_cnt_ff <= '0;
      end else if (!on_held) begin
         key_cnt_ff <= key_cnt_ff + 1'b1;
      end
   end

   // Qualify emergency pulse; act on release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         emg_cnt_ff <= '0;
         emg_armed_ff <= 1'b0;
      end else if (emergency_off_n) begin
         emg_cnt_ff <= '0;
         emg_armed_ff <= 1'b0;
      end else begin
         if (emg_cnt_ff < EMERG_HOLD) begin
            emg_cnt_ff <= emg_cnt_ff + 1'b1;
         end
         emg_armed_ff <= (emg_cnt_ff + 1'b1) >= EMERG_HOLD;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         det_cnt_ff <= '0;
      end else if (state_ff != mpo_pkg::ST_DETACH) begin
         det_cnt_ff <= '0;
      end else begin
         det_cnt_ff <= det_cnt_ff + 1'b1;
      end
   end

   // ******************************
   // Sequencer
   // ******************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         mpo_pkg::ST_OFF: begin
            if (on_held) begin
               nxt_state = mpo_pkg::ST_WAIT_ON_REL;
            end
         end
         mpo_pkg::ST_WAIT_ON_REL: begin
            if (!key_low) begin
               nxt_state = mpo_pkg::ST_ON;
            end
         end
         mpo_pkg::ST_ON: begin
            if (shutdown_command) begin
               nxt_state = mpo_pkg::ST_DETACH;
            end else if (off_held) begin
               nxt_state = mpo_pkg::ST_WAIT_REL;
            end
         end
         mpo_pkg::ST_WAIT_REL: begin
            if (!key_low) begin
               nxt_state = mpo_pkg::ST_DETACH;
            end
         end
         mpo_pkg::ST_DETACH: begin
            if (det_end) begin
               nxt_state = mpo_pkg::ST_OFF;
            end
         end
         default: nxt_state = mpo_pkg::ST_OFF;
      endcase
      if (emg_fire) begin
         nxt_state = mpo_pkg::ST_OFF;
      end
   end

   // Power-good level shown in each state
   function automatic logic pg_of(input mpo_pkg::mpo_state_t s);
      return (s == mpo_pkg::ST_ON) | (s == mpo_pkg::ST_WAIT_REL) |
         (s == mpo_pkg::ST_DETACH);
   endfunction

   wire nxt_pg = pg_of(nxt_state);
   wire nxt_det = (nxt_state == mpo_pkg::ST_DETACH);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= mpo_pkg::ST_OFF;
         power_good_out <= 1'b0;
         detach_req <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         power_good_out <= nxt_pg;
         detach_req <= nxt_det;
      end
   end

   // ******************************
   // Checks
   // ******************************
   a_off_pg_low: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_OFF |-> !power_good_out)
      else $error("power good high while off");
   a_on_pg_high: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_ON |-> power_good_out)
      else $error("power good low while on");
   a_emerg_off: assert property (@(posedge clk) disable iff (!rst_b)
      emg_fire |=> state_ff == mpo_pkg::ST_OFF && !power_good_out)
      else $error("emergency release did not power off");
   a_emerg_nodet: assert property (@(posedge clk) disable iff (!rst_b)
      emg_fire |=> !detach_req)
      else $error("detach raised on emergency path");
   a_detach_first: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(power_good_out) && !$past(emg_fire) |-> $past(detach_req))
      else $error("orderly off without detach");
   a_key_held: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_WAIT_REL && key_low && !emg_fire
      |=> !detach_req)
      else $error("shutdown began with key held");
   a_cmd_detach: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_ON && shutdown_command && !emg_fire
      |=> detach_req)
      else $error("command did not start detach");

   // ******************************
   // Transition checks
   // ******************************
   a_key_release: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_WAIT_REL && !key_low && !emg_fire
      |=> detach_req)
      else $error("key release did not start detach");
   a_short_key: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_ON && key_low && !off_held
      && !shutdown_command && !emg_fire |=> !detach_req)
      else $error("short key press began shutdown");
   a_key_on: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_WAIT_ON_REL && !key_low && !emg_fire
      |=> power_good_out)
      else $error("key release did not power on");
   a_pg_rise: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(power_good_out) |-> $past(state_ff) == mpo_pkg::ST_WAIT_ON_REL)
      else $error("power good rose outside power-on");

   a_detach_end: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_DETACH && detach_done && !emg_fire
      |=> !power_good_out && !detach_req)
      else $error("detach done did not power off");
   a_detach_tmo: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_DETACH &&
      det_cnt_ff == mpo_pkg::DETACH_TMO_CYC |=> state_ff == mpo_pkg::ST_OFF)
      else $error("detach timeout did not power off");
   a_done_ignored: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_ON && detach_done && !shutdown_command
      && !off_held && !emg_fire |=> state_ff == mpo_pkg::ST_ON)
      else $error("detach done acted outside detach");
   a_det_source: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(detach_req) |-> $past(state_ff) == mpo_pkg::ST_ON ||
      $past(state_ff) == mpo_pkg::ST_WAIT_REL)
      else $error("detach started outside an orderly request");

   a_off_stays: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_OFF && !on_held
      |=> !power_good_out && !detach_req)
      else $error("left off state without key hold");
   a_emerg_wait: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_ON && !emergency_off_n && !shutdown_command
      && !off_held |=> state_ff == mpo_pkg::ST_ON)
      else $error("emergency acted before release");
   a_emerg_short: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == mpo_pkg::ST_ON && emergency_off_n && !emg_armed_ff
      && !shutdown_command && !off_held |=> state_ff == mpo_pkg::ST_ON)
      else $error("unqualified emergency pulse acted");
endmodule

//--- dv/mpo_host_model.sv
// Purpose: Host side of the modem power control lines
// Assumes: Open-collector lines, a released line reads high
// Notes: Hold lengths come from the caller, in cycles
`timescale 1ns/100ps
module mpo_host_model (
   input wire logic clk, // System clock
   output logic power_key_n, // Key line, pulled up when released
   output logic emergency_off_n // Emergency line, pulled up when released
);
   initial begin
      power_key_n = 1'b1;
      emergency_off_n = 1'b1;
   end
   // Only ever pulls low or releases
   task automatic press(input bit emerg, input int n);
      @(posedge clk);
      if (emerg) begin
         emergency_off_n <= 1'b0;
      end else begin
         power_key_n <= 1'b0;
      end
      repeat (n) @(posedge clk);
      emergency_off_n <= 1'b1;
      power_key_n <= 1'b1;
   endtask
endmodule

//--- dv/tb.sv
// Purpose: Self-checking bench of the power-off sequencer
// Assumes: Short hold parameters, host model drives the lines
// Notes: One run ends through the detach timeout
`timescale 1ns/100ps
module tb;
   logic clk, rst_b, cmd, done, pk_n, eo_n, pg, dr, no_det;
   int n_fail = 0;
   int comparisons = 0;
   localparam logic [29:0] T_OFF = 30'h4;
   localparam logic [29:0] T_ON = 30'h8;
   localparam logic [29:0] T_EMERG = 30'h3;
   localparam int CMD_GAP = 8;
   int k;
   mpo_sequencer #(.OFF_HOLD(T_OFF), .ON_HOLD(T_ON), .EMERG_HOLD(T_EMERG))
      dut_u (.clk(clk), .rst_b(rst_b), .power_key_n(pk_n),
      .emergency_off_n(eo_n), .shutdown_command(cmd), .detach_done(done),
      .power_good_out(pg), .detach_req(dr));
   mpo_host_model host_u (.clk(clk), .power_key_n(pk_n),
      .emergency_off_n(eo_n));
   //****************
   // Helpers
   //****************
   task automatic chk(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %b want %b", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input bit d);
      @(posedge clk);
      if (d) done <= 1'b1;
      else cmd <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      cmd <= 1'b0;
   endtask
   function automatic int rnd(input int lo, input int span);
      return lo + int'($urandom % span);
   endfunction
   // Emergency pulse long enough to power off
   function automatic logic emg_kills(input int n);
      return n >= int'(T_EMERG);
   endfunction
   task automatic power_on;
      host_u.press(1'b0, rnd(int'(T_ON) + 1, 4));
      cyc(3);
      chk(pg, 1'b1);
      cyc(CMD_GAP);
   endtask
   task automatic close_out;
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // No detach while key held or on emergency path
   always @(negedge clk) if (no_det) chk(dr, 1'b0);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Timeout: longest run is the detach timeout plus a few hundred cycles
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      rst_b = 1'b0;
      cmd = 1'b0;
      done = 1'b0;
      no_det = 1'b0;
      void'($urandom(32'ha182453f));
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
      chk(pg, 1'b0);
      pulse(1'b0);
      cyc(2);
      chk(dr, 1'b0);
      power_on();
      pulse(1'b0);
      cyc(2);
      chk(dr, 1'b1);
      chk(pg, 1'b1);
      pulse(1'b1);
      cyc(2);
      chk(pg, 1'b0);
      chk(dr, 1'b0);
      power_on();
      no_det = 1'b1;
      host_u.press(1'b0, rnd(int'(T_OFF), 4));
      no_det = 1'b0;
      cyc(3);
      chk(dr, 1'b1);
      cyc(65540);
      chk(pg, 1'b0);
      power_on();
      no_det = 1'b1;
      host_u.press(1'b1, 2);
      cyc(4);
      chk(pg, 1'b1);
      repeat (4) begin
         k = rnd(1, 6);
         host_u.press(1'b1, k);
         cyc(4);
         chk(pg, !emg_kills(k));
         if (emg_kills(k)) power_on();
      end
      host_u.press(1'b1, rnd(int'(T_EMERG), 4));
      cyc(4);
      chk(pg, 1'b0);
      no_det = 1'b0;
      power_on();
      pulse(1'b1);
      cyc(2);
      chk(pg, 1'b1);
      chk(dr, 1'b0);
      pulse(1'b0);
      cyc(2);
      chk(dr, 1'b1);
      host_u.press(1'b1, rnd(int'(T_EMERG), 4));
      cyc(4);
      chk(dr, 1'b0);
      pulse(1'b1);
      cyc(2);
      chk(pg, 1'b0);
      power_on();
      @(posedge clk);
      rst_b <= 1'b0;
      #1;
      chk(pg, 1'b0);
      chk(dr, 1'b0);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      cyc(2);
      chk(pg, 1'b0);
      power_on();
      close_out();
   end
endmodule
